// *** pks_device.sv ***
`timescale 1ns/10ps
// Summary of operation
// - Host holds key low 500 ms to start
// - Key press of 100 ms starts module
// - Status rises 4.5 s after start press
// - USB and UART usable after 3.5 s
// - Key held 1.2 s while running shuts down
// - Status and interface outputs drop 2 s after shutdown begins
// - Software power-down command also shuts down
// - Reset pulse longer than 100 ms and shorter than 600 ms restarts
// - Software restart command acts as reset
// - Sample host dormant sense input
// - Flight request silences the radio
// - Key low wakes module from sleep
module pks_device
  import pks_pkg::*;
#(
  parameter logic [pks_pkg::CNT_W-1:0] ON_MIN = pks_pkg::ON_MIN_CYC,
  parameter logic [pks_pkg::CNT_W-1:0] SHUT_MIN = pks_pkg::SHUT_MIN_CYC,
  parameter logic [pks_pkg::CNT_W-1:0] IFACE_DLY = pks_pkg::IFACE_CYC,
  parameter logic [pks_pkg::CNT_W-1:0] STATUS_DLY = pks_pkg::STATUS_CYC,
  parameter logic [pks_pkg::CNT_W-1:0] OFF_DLY = pks_pkg::OFF_CYC,
  parameter logic [pks_pkg::CNT_W-1:0] RST_MIN = pks_pkg::RST_MIN_CYC,
  parameter logic [pks_pkg::CNT_W-1:0] RST_MAX = pks_pkg::RST_MAX_CYC
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Control pins from the host
  pks_if.dev_mp link,
  // Commands from the command interpreter, one-cycle pulses
  input wire logic cmd_power_down,
  input wire logic cmd_restart,
  input wire logic sleep_req,
  // Status toward the rest of the module
  output pks_pkg::pks_dev_state_type dev_state,
  output logic radio_on,
  output logic host_dormant
);
  import pks_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    pks_dev_state_type state; // Power state
    logic [CNT_W-1:0] key_cnt; // Cycles the key has been low
    logic [CNT_W-1:0] rst_cnt; // Cycles the reset line has been low
    logic [CNT_W-1:0] tmr; // Time in the boot or shutdown state
    logic key_armed; // Key seen released since last action
    logic key_q; // Key one cycle ago
    logic rst_q; // Reset line one cycle ago
    logic status; // Started indication
    logic iface; // USB and UART usable
    logic radio; // Radio active
    logic dormant; // Sampled host sleep sense
  } pks_dev_regs_type;

  pks_dev_regs_type dev_ff; // Registered state
  pks_dev_regs_type nxt_dev; // Next state
  logic key_rise; // Key released this cycle
  logic rst_rise; // Reset line released this cycle
  logic rst_valid; // Released reset pulse had a legal width

  // ----------------------------------------------------------------
  // Saturating increment, so a stuck pin cannot wrap a counter
  // ----------------------------------------------------------------
  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
    sat_inc = (&v) ? v : v + 27'h1;
  endfunction

  // ----------------------------------------------------------------
  // Pin edges
  // ----------------------------------------------------------------
  assign key_rise = link.power_key_n && !dev_ff.key_q;
  assign rst_rise = link.hard_reset_n && !dev_ff.rst_q;
  // Strict bounds at both ends of the window
  assign rst_valid = (dev_ff.rst_cnt > RST_MIN) && (dev_ff.rst_cnt < RST_MAX);

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_dev = dev_ff;
    nxt_dev.key_q = link.power_key_n;
    nxt_dev.rst_q = link.hard_reset_n;
    nxt_dev.dormant = link.host_sleep_sense;
    // Pulse width counters run in every state
    nxt_dev.key_cnt = link.power_key_n ? '0 : sat_inc(dev_ff.key_cnt);
    nxt_dev.rst_cnt = link.hard_reset_n ? '0 : sat_inc(dev_ff.rst_cnt);
    if (link.power_key_n)
    begin
      nxt_dev.key_armed = 1'b1;
    end

    unique case (dev_ff.state)
      DS_OFF:
      begin
        nxt_dev.status = 1'b0;
        nxt_dev.iface = 1'b0;
        nxt_dev.radio = 1'b0;
        // Start on release of a long enough press
        if (key_rise && dev_ff.key_armed && dev_ff.key_cnt >= ON_MIN)
        begin
          nxt_dev.tmr = '0;
          nxt_dev.state = DS_BOOT;
        end
      end
      DS_BOOT:
      begin
        nxt_dev.tmr = sat_inc(dev_ff.tmr);
        // Interfaces come up before the status indication
        if (dev_ff.tmr >= IFACE_DLY - 27'h1)
        begin
          nxt_dev.iface = 1'b1;
        end
        if (dev_ff.tmr >= STATUS_DLY - 27'h1)
        begin
          nxt_dev.status = 1'b1;
          nxt_dev.radio = !link.flight_req;
          nxt_dev.state = DS_RUN;
        end
      end
      DS_RUN:
      begin
        nxt_dev.radio = !link.flight_req;
        // Short presses just clear the counter on release
        // A press of exactly the minimum is seen at its release edge
        if (dev_ff.key_armed && dev_ff.key_cnt >= SHUT_MIN)
        begin
          nxt_dev.tmr = '0;
          nxt_dev.key_armed = 1'b0;
          nxt_dev.state = DS_SHUT;
        end
        else if (cmd_power_down)
        begin
          nxt_dev.tmr = '0;
          nxt_dev.state = DS_SHUT;
        end
        else if (sleep_req)
        begin
          nxt_dev.iface = 1'b0;
          nxt_dev.radio = 1'b0;
          nxt_dev.state = DS_SLEEP;
        end
      end
      DS_SHUT:
      begin
        nxt_dev.radio = 1'b0;
        nxt_dev.tmr = sat_inc(dev_ff.tmr);
        // Status and interfaces linger during the shutdown process
        if (dev_ff.tmr >= OFF_DLY - 27'h1)
        begin
          nxt_dev.status = 1'b0;
          nxt_dev.iface = 1'b0;
          nxt_dev.key_armed = 1'b0; // A still-held key must not restart
          nxt_dev.state = DS_OFF;
        end
      end
      DS_SLEEP:
      begin
        nxt_dev.radio = 1'b0;
        // Wake press does not count toward a shutdown press
        if (!link.power_key_n)
        begin
          nxt_dev.key_armed = 1'b0;
          nxt_dev.iface = 1'b1;
          nxt_dev.radio = !link.flight_req;
          nxt_dev.state = DS_RUN;
        end
      end
      DS_RESTART:
      begin
        nxt_dev.tmr = '0;
        nxt_dev.state = DS_BOOT;
      end
      default:
      begin
        nxt_dev.state = DS_OFF; // Recover from an illegal code
      end
    endcase

    // Restart overrides while powered, but not during shutdown
    if ((dev_ff.state == DS_BOOT || dev_ff.state == DS_RUN || dev_ff.state == DS_SLEEP)
        && ((rst_rise && rst_valid) || cmd_restart))
    begin
      nxt_dev.status = 1'b0;
      nxt_dev.iface = 1'b0;
      nxt_dev.radio = 1'b0;
      nxt_dev.tmr = '0;
      nxt_dev.state = DS_RESTART;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dev_ff <= '0;
      dev_ff.state <= DS_OFF;
      dev_ff.key_q <= 1'b1;
      dev_ff.rst_q <= 1'b1;
    end
    else
    begin
      dev_ff <= nxt_dev;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all from flip-flops
  // ----------------------------------------------------------------
  assign link.status_on = dev_ff.status;
  assign link.iface_ready = dev_ff.iface;
  assign dev_state = dev_ff.state;
  assign radio_on = dev_ff.radio;
  assign host_dormant = dev_ff.dormant;

endmodule

// *** pks_pkg.sv ***
package pks_pkg;

  // ----------------------------------------------------------------
  // Clock and counter sizing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 20_000_000; // System clock rate
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000; // Cycles in one ms
  localparam int unsigned CNT_W = 27; // Holds 4.5 s worth of cycles

  // ----------------------------------------------------------------
  // Times in milliseconds, as specified
  // ----------------------------------------------------------------
  localparam int unsigned ON_MIN_MS = 100; // Shortest accepted switch-on press
  localparam int unsigned ON_PRESS_MS = 500; // Host switch-on press
  localparam int unsigned SHUT_MIN_MS = 1200; // Shortest switch-off press
  localparam int unsigned OFF_PRESS_MS = 1500; // Host switch-off press, with margin
  localparam int unsigned IFACE_MS = 3500; // USB and UART usable after start
  localparam int unsigned STATUS_MS = 4500; // Status shows started
  localparam int unsigned OFF_MS = 2000; // Status and interface outputs drop after shutdown begins
  localparam int unsigned RST_MIN_MS = 100; // Reset pulse must exceed this
  localparam int unsigned RST_MAX_MS = 600; // Reset pulse must stay below this
  localparam int unsigned RST_PULSE_MS = 300; // Host reset pulse

  // ----------------------------------------------------------------
  // Derived cycle counts (whole ms, so no rounding arises)
  // ----------------------------------------------------------------
  localparam logic [CNT_W-1:0] ON_MIN_CYC = CNT_W'(ON_MIN_MS * CYC_PER_MS);
  localparam logic [CNT_W-1:0] ON_PRESS_CYC = CNT_W'(ON_PRESS_MS * CYC_PER_MS);
  localparam logic [CNT_W-1:0] SHUT_MIN_CYC = CNT_W'(SHUT_MIN_MS * CYC_PER_MS);
  localparam logic [CNT_W-1:0] OFF_PRESS_CYC = CNT_W'(OFF_PRESS_MS * CYC_PER_MS);
  localparam logic [CNT_W-1:0] IFACE_CYC = CNT_W'(IFACE_MS * CYC_PER_MS);
  localparam logic [CNT_W-1:0] STATUS_CYC = CNT_W'(STATUS_MS * CYC_PER_MS);
  localparam logic [CNT_W-1:0] OFF_CYC = CNT_W'(OFF_MS * CYC_PER_MS);
  localparam logic [CNT_W-1:0] RST_MIN_CYC = CNT_W'(RST_MIN_MS * CYC_PER_MS);
  localparam logic [CNT_W-1:0] RST_MAX_CYC = CNT_W'(RST_MAX_MS * CYC_PER_MS);
  localparam logic [CNT_W-1:0] RST_PULSE_CYC = CNT_W'(RST_PULSE_MS * CYC_PER_MS);
  localparam logic [CNT_W-1:0] WAKE_WAIT_CYC = 27'h1; // Wake needs no boot wait

  // ----------------------------------------------------------------
  // State encodings
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    DS_OFF = 6'h01,
    DS_BOOT = 6'h02,
    DS_RUN = 6'h04,
    DS_SHUT = 6'h08,
    DS_SLEEP = 6'h10,
    DS_RESTART = 6'h20
  } pks_dev_state_type;

  typedef enum logic [2:0] {
    HS_IDLE = 3'h1,
    HS_PRESS = 3'h2,
    HS_WAIT = 3'h4
  } pks_host_state_type;

endpackage

// *** pks_if.sv ***
`timescale 1ns/10ps
// ------------------------------------------------------------------
// Control pins between host and module
// ------------------------------------------------------------------
interface pks_if;
  logic power_key_n; // Power key, low while pressed
  logic hard_reset_n; // Hard reset line, low while asserted
  logic flight_req; // High asks the module to silence its radio
  logic host_sleep_sense; // High while host processor is dormant
  logic status_on; // Module started indication
  logic iface_ready; // USB and UART usable

  // Module end
  modport dev_mp (
    input power_key_n,
    input hard_reset_n,
    input flight_req,
    input host_sleep_sense,
    output status_on,
    output iface_ready
  );

  // Host end
  modport host_mp (
    output power_key_n,
    output hard_reset_n,
    output flight_req,
    output host_sleep_sense,
    input status_on,
    input iface_ready
  );
endinterface

// *** pks_host.sv ***
`timescale 1ns/10ps
// ------------------------------------------------------------------
// Host end: times key and reset pulses for its user
// ------------------------------------------------------------------
module pks_host
  import pks_pkg::*;
#(
  parameter logic [pks_pkg::CNT_W-1:0] PRESS_ON_CYC = pks_pkg::ON_PRESS_CYC,
  parameter logic [pks_pkg::CNT_W-1:0] PRESS_OFF_CYC = pks_pkg::OFF_PRESS_CYC,
  parameter logic [pks_pkg::CNT_W-1:0] RST_LOW_CYC = pks_pkg::RST_PULSE_CYC,
  parameter logic [pks_pkg::CNT_W-1:0] BOOT_WAIT_CYC = pks_pkg::IFACE_CYC,
  parameter logic [pks_pkg::CNT_W-1:0] OFF_WAIT_CYC = pks_pkg::OFF_CYC
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Pins toward the module
  pks_if.host_mp link,
  // User requests, one-cycle pulses
  input wire logic req_on,
  input wire logic req_off,
  input wire logic req_wake,
  input wire logic req_reset,
  // User levels passed to the module
  input wire logic flight_on,
  input wire logic host_dormant,
  // User status
  output logic busy,
  output logic link_usable
);
  import pks_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    pks_host_state_type state; // Sequence step
    logic [CNT_W-1:0] cnt; // Cycles in this step
    logic [CNT_W-1:0] wait_cyc; // Wait length after the pulse
    logic key_n; // Power key drive
    logic rst_line_n; // Reset line drive
    logic flight; // Flight request drive
    logic dormant; // Sleep sense drive
    logic usable; // Traffic allowed
  } pks_host_regs_type;

  pks_host_regs_type host_ff; // Registered state
  pks_host_regs_type nxt_host; // Next state

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_host = host_ff;
    nxt_host.flight = flight_on;
    nxt_host.dormant = host_dormant;
    unique case (host_ff.state)
      HS_IDLE:
      begin
        nxt_host.cnt = '0;
        // Reset wins over every other request
        if (req_reset)
        begin
          nxt_host.rst_line_n = 1'b0;
          nxt_host.usable = 1'b0;
          nxt_host.wait_cyc = BOOT_WAIT_CYC;
          nxt_host.state = HS_PRESS;
        end
        else if (req_off)
        begin
          nxt_host.key_n = 1'b0;
          nxt_host.usable = 1'b0;
          nxt_host.wait_cyc = OFF_WAIT_CYC;
          nxt_host.state = HS_PRESS;
        end
        else if (req_on || req_wake)
        begin
          nxt_host.key_n = 1'b0;
          nxt_host.wait_cyc = req_on ? BOOT_WAIT_CYC : WAKE_WAIT_CYC;
          nxt_host.state = HS_PRESS;
        end
      end
      HS_PRESS:
      begin
        nxt_host.cnt = host_ff.cnt + 27'h1;
        // Release after the chosen width
        if (!host_ff.rst_line_n && host_ff.cnt >= RST_LOW_CYC - 27'h1)
        begin
          nxt_host.rst_line_n = 1'b1;
          nxt_host.cnt = '0;
          nxt_host.state = HS_WAIT;
        end
        else if (!host_ff.key_n && host_ff.wait_cyc == OFF_WAIT_CYC
                 && host_ff.cnt >= PRESS_OFF_CYC - 27'h1)
        begin
          nxt_host.key_n = 1'b1;
          nxt_host.cnt = '0;
          nxt_host.state = HS_WAIT;
        end
        else if (!host_ff.key_n && host_ff.wait_cyc != OFF_WAIT_CYC
                 && host_ff.cnt >= PRESS_ON_CYC - 27'h1)
        begin
          nxt_host.key_n = 1'b1;
          nxt_host.cnt = '0;
          nxt_host.state = HS_WAIT;
        end
      end
      HS_WAIT:
      begin
        nxt_host.cnt = host_ff.cnt + 27'h1;
        // No traffic expected before the boot wait ends
        if (host_ff.cnt >= host_ff.wait_cyc - 27'h1)
        begin
          nxt_host.usable = (host_ff.wait_cyc != OFF_WAIT_CYC);
          nxt_host.state = HS_IDLE;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      host_ff <= '0;
      host_ff.state <= HS_IDLE;
      host_ff.key_n <= 1'b1;
      host_ff.rst_line_n <= 1'b1;
    end
    else
    begin
      host_ff <= nxt_host;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign link.power_key_n = host_ff.key_n;
  assign link.hard_reset_n = host_ff.rst_line_n;
  assign link.flight_req = host_ff.flight;
  assign link.host_sleep_sense = host_ff.dormant;
  assign busy = (host_ff.state != HS_IDLE); // Requests ignored while high
  assign link_usable = host_ff.usable;

endmodule

// *** pks_monitor.sv ***
`timescale 1ns/10ps
// ----------------------------------------
// Pin-level checks on the host to module link
// ----------------------------------------
module pks_monitor #(
  parameter int IFACE_DLY = 80,
  parameter int STATUS_DLY = 100,
  parameter int OFF_DLY = 50,
  parameter int SHUT_MIN = 30,
  parameter int RST_MIN = 10,
  parameter int RST_MAX = 60,
  parameter int PRESS_ON = 20,
  parameter int PRESS_OFF = 40,
  parameter int RST_LOW = 30
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Host to module
  input wire logic power_key_n,
  input wire logic hard_reset_n,
  // Module to host
  input wire logic status_on,
  input wire logic iface_ready
);
  localparam int IFACE_LO = IFACE_DLY - 1; // Interface still low here
  localparam int BOOT_GAP = STATUS_DLY - IFACE_DLY; // Interface to status
  localparam int SHUT_STAY = SHUT_MIN + OFF_DLY - 2; // Status still high here
  int key_lo_ff; // Consecutive low key samples
  int rst_lo_ff; // Consecutive low reset samples

  // Pulse width counters, cleared by any high sample
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      key_lo_ff <= 0;
      rst_lo_ff <= 0;
    end
    else
    begin
      key_lo_ff <= power_key_n ? 0 : key_lo_ff + 1;
      rst_lo_ff <= hard_reset_n ? 0 : rst_lo_ff + 1;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // Boot wait, then the interface comes up
  sequence s_iface_up;
    ##(IFACE_LO) !iface_ready ##[1:3] iface_ready;
  endsequence
  // Shutdown: status held through the wait, then dropped
  sequence s_shut_drop;
    ##(SHUT_STAY) status_on ##[1:5] !status_on;
  endsequence

  chk_key_width: assert property (
    $rose(power_key_n) |-> key_lo_ff == PRESS_ON || key_lo_ff == PRESS_OFF)
    else $error("key press width wrong");
  chk_reset_width: assert property (
    $rose(hard_reset_n) |-> rst_lo_ff == RST_LOW && RST_LOW > RST_MIN && RST_LOW < RST_MAX)
    else $error("reset pulse width wrong");
  chk_iface_boot: assert property (
    $rose(power_key_n) && !status_on && !iface_ready |-> s_iface_up)
    else $error("interface came up at wrong time");
  chk_boot_gap: assert property (
    $rose(iface_ready) && !status_on |-> ##(BOOT_GAP) $rose(status_on))
    else $error("status rose at wrong time");
  chk_shut_hold: assert property (
    $fell(power_key_n) && status_on && iface_ready |-> s_shut_drop)
    else $error("shutdown timing wrong");
  chk_off_quiet: assert property (
    $fell(status_on) |-> !iface_ready [*8])
    else $error("interface alive after status drop");
  chk_wake_iface: assert property (
    $fell(power_key_n) && status_on && !iface_ready |-> ##[1:2] iface_ready)
    else $error("no wake from sleep");
  chk_reset_hold: assert property (
    $fell(hard_reset_n) && status_on |-> status_on [*8])
    else $error("reset acted before release");
  chk_reset_boot: assert property (
    $rose(hard_reset_n) && status_on |-> ##1 (!status_on && !iface_ready) ##0 s_iface_up)
    else $error("no restart after reset pulse");
endmodule

// *** tb_module_power_key_reset_seq.sv ***
`timescale 1ns/10ps
module tb_module_power_key_reset_seq;
  import pks_pkg::*;
  // ----------------------------------------
  // Shortened timing set, order kept except between reset times and the others
  // ----------------------------------------
  localparam int P_ON_MIN = 32'h0a;
  localparam int P_SHUT_MIN = 32'h1e;
  localparam int P_IFACE = 32'h50;
  localparam int P_STATUS = 32'h64;
  localparam int P_OFF = 32'h32;
  localparam int P_RST_MIN = 32'h0a;
  localparam int P_RST_MAX = 32'h3c;
  localparam int P_PON = 32'h14;
  localparam int P_POFF = 32'h28;
  localparam int P_RLOW = 32'h1e;
  logic clk_sys = 1'b0; // System clock
  logic rst_n = 1'b0; // Reset, low at start
  logic [6:0] req = 7'h00; // On, off, wake, reset, power-down, restart, sleep
  logic flight_on = 1'b0; // Flight level
  logic dormant = 1'b0; // Host dormant level
  logic [1:0] rnd; // Random start for level sweep
  logic busy; // Host sequence running
  logic link_usable; // Host may use interfaces
  logic [1:0] radio; // Radio active per end
  logic [1:0] dorm; // Dormant copy per end
  pks_dev_state_type st [2]; // Module states
  logic [7:0] res [2]; // Watched {state, iface, status}
  logic [7:0] last [2]; // Previous watched value
  logic [7:0] expq [2][$]; // Expected notes, oldest first
  int fail_count = 0;
  int num_checks = 0;
  pks_if link[2](); // A: host pair, B: driven here directly

  always #25 clk_sys = ~clk_sys;

  pks_host #(.PRESS_ON_CYC(CNT_W'(P_PON)), .PRESS_OFF_CYC(CNT_W'(P_POFF)),
    .RST_LOW_CYC(CNT_W'(P_RLOW)), .BOOT_WAIT_CYC(CNT_W'(P_IFACE)),
    .OFF_WAIT_CYC(CNT_W'(P_OFF))) i_pks_host (.clk_sys(clk_sys), .rst_n(rst_n),
    .link(link[0]), .req_on(req[0]), .req_off(req[1]), .req_wake(req[2]),
    .req_reset(req[3]), .flight_on(flight_on), .host_dormant(dormant), .busy(busy),
    .link_usable(link_usable));

  // Two module ends; only end A gets commands, end B is for pulses at both edges of the key and reset minimums and at the reset maximum
  for (genvar g = 0; g < 2; g++)
  begin : g_end
    pks_device #(.ON_MIN(CNT_W'(P_ON_MIN)), .SHUT_MIN(CNT_W'(P_SHUT_MIN)),
      .IFACE_DLY(CNT_W'(P_IFACE)), .STATUS_DLY(CNT_W'(P_STATUS)), .OFF_DLY(CNT_W'(P_OFF)),
      .RST_MIN(CNT_W'(P_RST_MIN)), .RST_MAX(CNT_W'(P_RST_MAX))) i_pks_device (
      .clk_sys(clk_sys), .rst_n(rst_n), .link(link[g]),
      .cmd_power_down(req[4] & (g == 0)), .cmd_restart(req[5] & (g == 0)),
      .sleep_req(req[6] & (g == 0)), .dev_state(st[g]), .radio_on(radio[g]),
      .host_dormant(dorm[g]));
  end

  pks_monitor #(.IFACE_DLY(P_IFACE), .STATUS_DLY(P_STATUS), .OFF_DLY(P_OFF),
    .SHUT_MIN(P_SHUT_MIN), .RST_MIN(P_RST_MIN), .RST_MAX(P_RST_MAX), .PRESS_ON(P_PON),
    .PRESS_OFF(P_POFF), .RST_LOW(P_RLOW)) i_pks_monitor (.clk_sys(clk_sys), .rst_n(rst_n),
    .power_key_n(link[0].power_key_n), .hard_reset_n(link[0].hard_reset_n),
    .status_on(link[0].status_on), .iface_ready(link[0].iface_ready));

  // Watched vectors
  always_comb
  begin
    res[0] = {st[0], link[0].iface_ready, link[0].status_on};
    res[1] = {st[1], link[1].iface_ready, link[1].status_on};
  end

  // Each change is matched against the oldest note; no note means a stray change
  always @(negedge clk_sys)
  begin
    for (int k = 0; k < 2; k++)
    begin
      if (rst_n && res[k] !== last[k])
      begin
        num_checks++;
        if (expq[k].size() == 0 || expq[k][0] !== res[k])
        begin
          fail_count++;
          $display("unexpected at %0t: end %0d shows %h", $time, k, res[k]);
        end
        if (expq[k].size() != 0)
          void'(expq[k].pop_front());
      end
      last[k] = res[k];
    end
  end

  task automatic check(input logic got, input logic exp);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: level %b, wanted %b", $time, got, exp);
    end
  endtask

  // One-cycle request pulse, launched off the sampling edge
  task automatic pulse(input int b);
    @(negedge clk_sys);
    req[b] = 1'b1;
    @(negedge clk_sys);
    req[b] = 1'b0;
  endtask

  task automatic note(input int k, input pks_dev_state_type s, input logic [1:0] io);
    expq[k].push_back({s, io});
  endtask

  task automatic boot_notes(input int k);
    note(k, DS_BOOT, 2'b00);
    note(k, DS_BOOT, 2'b10);
    note(k, DS_RUN, 2'b11);
  endtask

  task automatic shut_notes(input int k);
    note(k, DS_SHUT, 2'b11);
    note(k, DS_OFF, 2'b00);
  endtask

  // End B: key (w=0) or reset (w=1) low for exactly n samples
  task automatic low_b(input int w, input int n);
    @(negedge clk_sys);
    {link[1].power_key_n, link[1].hard_reset_n} = w ? 2'b10 : 2'b01;
    repeat (n) @(negedge clk_sys);
    {link[1].power_key_n, link[1].hard_reset_n} = 2'b11;
    repeat (3) @(negedge clk_sys);
  endtask

  // Bounded wait until all notes are met and the host is idle
  task automatic drain(input string name);
    int n = 0;
    while ((expq[0].size() + expq[1].size() != 0 || busy !== 1'b0) && n < 3000)
    begin
      @(negedge clk_sys);
      n++;
    end
    if (n == 3000)
    begin
      fail_count++;
      $display("unexpected at %0t: %s stalled", $time, name);
    end
    $display("test %s done at %0t", name, $time);
  endtask

  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    {link[1].power_key_n, link[1].hard_reset_n, link[1].flight_req,
      link[1].host_sleep_sense} = 4'hc;
    void'($urandom(32'he299));
    rnd = 2'($urandom);
    repeat (2) @(negedge clk_sys);
    rst_n = 1'b1;
    boot_notes(0);
    pulse(0);
    drain("power on");
    check(link_usable, 1'b1);
    // Sweep all flight and dormant pairs from a random start
    for (int k = 0; k < 4; k++)
    begin
      {flight_on, dormant} = 2'(k) ^ rnd;
      repeat (3) @(negedge clk_sys);
      check(radio[0], ~flight_on);
      check(dorm[0], dormant);
    end
    flight_on = 1'b0;
    repeat (3) @(negedge clk_sys);
    note(0, DS_SLEEP, 2'b01);
    note(0, DS_RUN, 2'b11);
    pulse(6);
    pulse(2);
    drain("sleep and wake");
    note(0, DS_RESTART, 2'b00);
    boot_notes(0);
    pulse(3);
    drain("reset pulse");
    note(0, DS_RESTART, 2'b00);
    boot_notes(0);
    pulse(5);
    drain("restart command");
    shut_notes(0);
    pulse(4);
    drain("power-down command");
    boot_notes(0);
    pulse(0);
    drain("second power on");
    shut_notes(0);
    pulse(1);
    drain("key shutdown");
    check(link_usable, 1'b0);
    low_b(0, P_ON_MIN - 1);
    boot_notes(1);
    low_b(0, P_ON_MIN);
    drain("shortest switch-on press");
    low_b(1, P_RST_MIN);
    low_b(1, P_RST_MAX);
    note(1, DS_RESTART, 2'b00);
    boot_notes(1);
    low_b(1, P_RST_MIN + 1);
    drain("reset widths");
    low_b(0, P_SHUT_MIN - 1);
    shut_notes(1);
    low_b(0, P_SHUT_MIN);
    drain("shortest switch-off press");
    end_of_test();
  end

  // Watchdog, far beyond the thousand or so cycles the tests need
  initial
  begin
    repeat (32'h4e20) @(posedge clk_sys);
    fail_count++;
    end_of_test();
  end
endmodule
